// ===== rtl/rgbd_controller.v
// Functional notes
// - a loop timer paces each full control pass to about 10 ms.
// - each pass runs either colour mix or temperature step, alternating every pass.
// - every pass reloads all three modulators with the current dimming values.
// - i2c target stores each written byte for index 0..4 into the request store, never stalling loop.
// - host may update x, y, flux any time; steps read current store.
// - coordinates are 16-bit unsigned, 10000 counts equals one.
// - flux request is one unsigned byte of lumens.
// - three channels red, green, blue, each with its own dimming value.
// - channels use stochastic density modulation, not fixed-period pulse width.
// - modulator density is n over 255 for 8-bit input n.
// - density is linear in the input value.
// - initialization runs once after reset release, before the first pass.
// - out-of-gamut request turns channels off and flags error; excess flux is clipped.
`timescale 1ns/1ps
`default_nettype none
`include "rgbd_defs.vh"

module rgbd_controller #(
    parameter [31:0] LOOP_CYC = `RGBD_LOOP_CYC
) (
    // clock and reset
    input  wire       clk,
    input  wire       rstn,
    // i2c pins
    input  wire       sclIn,
    input  wire       sdaIn,
    output wire       sdaOeN,
    // board temperature code
    input  wire [7:0] tempIn,
    // led channels
    output wire       ledRed,
    output wire       ledGreen,
    output wire       ledBlue,
    // status
    output reg        gamutErr_q,
    output reg        passStrobe_q
);

    localparam ST_INIT  = 2'b00;
    localparam ST_WAIT  = 2'b01;
    localparam ST_STEP  = 2'b10;
    localparam ST_DRIVE = 2'b11;

    reg  [7:0]  store_q [0:4];
    reg  [1:0]  state_q;
    reg  [3:0]  initCnt_q;
    reg  [31:0] loopCnt_q;
    reg         doTemp_q;
    reg  [7:0]  fluxLimit_q;
    reg  [7:0]  tempSync0_q;
    reg  [7:0]  tempSync1_q;
    reg  [7:0]  mixR_q;
    reg  [7:0]  mixG_q;
    reg  [7:0]  mixB_q;
    reg  [7:0]  dimR_q;
    reg  [7:0]  dimG_q;
    reg  [7:0]  dimB_q;
    reg         mixErr_q;
    reg  [1:0]  state_d;
    reg  [3:0]  initCnt_d;
    reg  [31:0] loopCnt_d;
    reg         doTemp_d;
    reg  [7:0]  fluxLimit_d;
    reg  [7:0]  mixR_d;
    reg  [7:0]  mixG_d;
    reg  [7:0]  mixB_d;
    reg         mixErr_d;
    reg  [7:0]  dimR_d;
    reg  [7:0]  dimG_d;
    reg  [7:0]  dimB_d;
    reg         gamutErr_d;
    reg         passStrobe_d;
    wire        wrEn;
    wire [7:0]  wrIdx;
    wire [7:0]  wrData;
    wire [15:0] coordX;
    wire [15:0] coordY;
    wire [7:0]  fluxReq;
    wire [16:0] sumXY;
    wire        outOfGamut;
    wire [7:0]  fluxEff;
    wire [15:0] wBlue;
    wire [7:0]  tempOver;
    wire [7:0]  limitNext;

    // scale a weight in coordinate counts and a flux into an 8-bit dim value
    function [7:0] dim_of;
        input [15:0] w;
        input [7:0]  f;
        reg   [47:0] prod;
        reg   [47:0] sh;
        begin
            prod = {32'h0, w} * {40'h0, f} * {34'h0, `RGBD_DIM_MULT};
            sh   = prod >> `RGBD_DIM_SHIFT;
            if (sh > {40'h0, `RGBD_DIM_FULL}) begin
                dim_of = `RGBD_DIM_FULL;
            end else begin
                dim_of = sh[7:0];
            end
        end
    endfunction

    rgbd_i2c_target u_i2c (
        .clk      (clk),
        .rstn     (rstn),
        .sclIn    (sclIn),
        .sdaIn    (sdaIn),
        .sdaOeN_q (sdaOeN),
        .wrEn_q   (wrEn),
        .wrIdx_q  (wrIdx),
        .wrData_q (wrData)
    );

    // request store written straight from the link, independent of the loop
    always @(posedge clk) begin
        if (!rstn) begin
            store_q[0] <= `RGBD_STORE_RST;
            store_q[1] <= `RGBD_STORE_RST;
            store_q[2] <= `RGBD_STORE_RST;
            store_q[3] <= `RGBD_STORE_RST;
            store_q[4] <= `RGBD_STORE_RST;
        end else if (wrEn && wrIdx <= `RGBD_STORE_LAST) begin
            store_q[wrIdx[2:0]] <= wrData;
        end
    end

    // big-endian words, 10000 counts per unit
    assign coordX  = {store_q[`RGBD_IDX_X_HI], store_q[`RGBD_IDX_X_LO]};
    assign coordY  = {store_q[`RGBD_IDX_Y_HI], store_q[`RGBD_IDX_Y_LO]};
    assign fluxReq = store_q[`RGBD_IDX_FLUX];

    // simplified gamut: weights x, y and 1-x-y must all be non-negative
    assign sumXY      = {1'b0, coordX} + {1'b0, coordY};
    assign outOfGamut = (sumXY > {1'b0, `RGBD_COORD_ONE});
    assign wBlue      = outOfGamut ? 16'h0000 : (`RGBD_COORD_ONE - sumXY[15:0]);
    assign fluxEff    = (fluxReq > fluxLimit_q) ? fluxLimit_q : fluxReq;

    // temperature step derates the reachable flux above a knee
    assign tempOver  = (tempSync1_q > `RGBD_TEMP_KNEE) ? (tempSync1_q - `RGBD_TEMP_KNEE)
                                                       : 8'h00;
    assign limitNext = (tempOver > (`RGBD_FLUX_MAX - `RGBD_TEMP_FLOOR)) ? `RGBD_TEMP_FLOOR
                                                                        : (`RGBD_FLUX_MAX - tempOver);

    always @(posedge clk) begin
        if (!rstn) begin
            tempSync0_q <= 8'h00;
            tempSync1_q <= 8'h00;
        end else begin
            tempSync0_q <= tempIn;
            tempSync1_q <= tempSync0_q;
        end
    end

    // next-state logic for the loop sequencer
    always @* begin
        state_d      = state_q;
        initCnt_d    = initCnt_q;
        loopCnt_d    = loopCnt_q + 32'h1;
        doTemp_d     = doTemp_q;
        fluxLimit_d  = fluxLimit_q;

        mixR_d       = mixR_q;
        mixG_d       = mixG_q;
        mixB_d       = mixB_q;
        mixErr_d     = mixErr_q;

        dimR_d       = dimR_q;
        dimG_d       = dimG_q;
        dimB_d       = dimB_q;
        gamutErr_d   = gamutErr_q;
        passStrobe_d = 1'b0;

        case (state_q)
            // reached only from reset
            ST_INIT: begin
                fluxLimit_d = `RGBD_FLUX_MAX;
                initCnt_d   = initCnt_q + 4'h1;
                loopCnt_d   = 32'h0;
                if (initCnt_q == `RGBD_INIT_CYC - 4'h1) begin
                    state_d = ST_STEP;
                end
            end
            ST_STEP: begin
                if (doTemp_q) begin
                    fluxLimit_d = limitNext;
                end else if (outOfGamut) begin
                    mixR_d   = 8'h00;
                    mixG_d   = 8'h00;
                    mixB_d   = 8'h00;
                    mixErr_d = 1'b1;
                end else begin
                    mixR_d   = dim_of(coordX, fluxEff);
                    mixG_d   = dim_of(coordY, fluxEff);
                    mixB_d   = dim_of(wBlue, fluxEff);
                    mixErr_d = 1'b0;
                end
                doTemp_d = ~doTemp_q;
                state_d  = ST_DRIVE;
            end
            ST_DRIVE: begin
                // temperature passes reload the old mix, so dims never go stale
                dimR_d     = mixR_q;
                dimG_d     = mixG_q;
                dimB_d     = mixB_q;
                gamutErr_d = mixErr_q;
                state_d    = ST_WAIT;
            end
            ST_WAIT: begin
                // pass length is fixed by the counter, not by step work
                if (loopCnt_q >= LOOP_CYC - 32'h1) begin
                    loopCnt_d    = 32'h0;
                    passStrobe_d = 1'b1;
                    state_d      = ST_STEP;
                end
            end
            default: begin
                state_d = ST_WAIT;
            end
        endcase
    end

    // registers only; all decisions live in the next-state logic
    always @(posedge clk) begin
        if (!rstn) begin
            state_q      <= ST_INIT;
            initCnt_q    <= 4'h0;
            loopCnt_q    <= 32'h0;
            doTemp_q     <= 1'b0;
            fluxLimit_q  <= 8'h00;
            mixR_q       <= 8'h00;
            mixG_q       <= 8'h00;
            mixB_q       <= 8'h00;
            mixErr_q     <= 1'b0;
            dimR_q       <= 8'h00;
            dimG_q       <= 8'h00;
            dimB_q       <= 8'h00;
            gamutErr_q   <= 1'b0;
            passStrobe_q <= 1'b0;
        end else begin
            state_q      <= state_d;
            initCnt_q    <= initCnt_d;
            loopCnt_q    <= loopCnt_d;
            doTemp_q     <= doTemp_d;
            fluxLimit_q  <= fluxLimit_d;
            mixR_q       <= mixR_d;
            mixG_q       <= mixG_d;
            mixB_q       <= mixB_d;
            mixErr_q     <= mixErr_d;
            dimR_q       <= dimR_d;
            dimG_q       <= dimG_d;
            dimB_q       <= dimB_d;
            gamutErr_q   <= gamutErr_d;
            passStrobe_q <= passStrobe_d;
        end
    end

    rgbd_density_mod u_red (
        .clk      (clk),
        .rstn     (rstn),
        .level    (dimR_q),
        .ledOut_q (ledRed)
    );

    rgbd_density_mod u_green (
        .clk      (clk),
        .rstn     (rstn),
        .level    (dimG_q),
        .ledOut_q (ledGreen)
    );

    rgbd_density_mod u_blue (
        .clk      (clk),
        .rstn     (rstn),
        .level    (dimB_q),
        .ledOut_q (ledBlue)
    );

endmodule // rgbd_controller

`default_nettype wire

// ===== rtl/rgbd_defs.vh
`ifndef RGBD_DEFS_VH
`define RGBD_DEFS_VH

// loop pacing
`define RGBD_CLK_HZ          200000000
`define RGBD_LOOP_MS         10
`define RGBD_LOOP_CYC        ((`RGBD_CLK_HZ / 1000) * `RGBD_LOOP_MS)
`define RGBD_INIT_CYC        4'h8

// request store layout
`define RGBD_IDX_X_HI        3'h0
`define RGBD_IDX_X_LO        3'h1
`define RGBD_IDX_Y_HI        3'h2
`define RGBD_IDX_Y_LO        3'h3
`define RGBD_IDX_FLUX        3'h4
`define RGBD_STORE_LAST      8'h04
`define RGBD_STORE_RST       8'h00

// coordinate scaling: 10000 counts is exactly one
`define RGBD_COORD_ONE       16'h2710

// flux limits and dim scaling: dim = w * flux * MULT >> SHIFT
`define RGBD_FLUX_MAX        8'hc8
`define RGBD_DIM_MULT        14'h216d
`define RGBD_DIM_SHIFT       26
`define RGBD_DIM_FULL        8'hff

// temperature derating
`define RGBD_TEMP_KNEE       8'h50
`define RGBD_TEMP_FLOOR      8'h20

// i2c target
`define RGBD_I2C_ADDR        7'h2a
`define RGBD_BIT_LAST        4'h8

// lfsr taps x^8+x^6+x^5+x^4+1, nonzero seed
`define RGBD_LFSR_SEED       8'h01

`endif

// ===== rtl/rgbd_density_mod.v
`timescale 1ns/1ps
`default_nettype none
`include "rgbd_defs.vh"

module rgbd_density_mod (
    // clock and reset
    input  wire       clk,
    input  wire       rstn,
    // density value
    input  wire [7:0] level,
    // modulated output
    output reg        ledOut_q
);

    reg  [7:0] lfsr_q;
    wire       fb;

    assign fb = lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3];

    // lfsr walks 1..255 once per 255 clocks, so level >= lfsr hits n of them
    always @(posedge clk) begin
        if (!rstn) begin
            lfsr_q   <= `RGBD_LFSR_SEED;
            ledOut_q <= 1'b0;
        end else begin
            lfsr_q   <= {lfsr_q[6:0], fb};
            ledOut_q <= (level >= lfsr_q);
        end
    end

endmodule // rgbd_density_mod

`default_nettype wire

// ===== rtl/rgbd_i2c_target.v
`timescale 1ns/1ps
`default_nettype none
`include "rgbd_defs.vh"

module rgbd_i2c_target (
    // clock and reset
    input  wire       clk,
    input  wire       rstn,
    // i2c pins
    input  wire       sclIn,
    input  wire       sdaIn,
    output reg        sdaOeN_q,
    // store write port
    output reg        wrEn_q,
    output reg  [7:0] wrIdx_q,
    output reg  [7:0] wrData_q
);

    localparam ST_IDLE = 2'b00;
    localparam ST_ADDR = 2'b01;
    localparam ST_DATA = 2'b10;
    localparam ST_ACK  = 2'b11;

    reg  [2:0] sclSync_q;
    reg  [2:0] sdaSync_q;
    reg  [1:0] state_q;
    reg  [3:0] bitCnt_q;
    reg  [7:0] shift_q;
    reg        first_q;
    reg  [7:0] ptr_q;
    wire       sclRise;
    wire       sclFall;
    wire       startSeen;
    wire       stopSeen;

    // stage 0 is read only by stage 1
    assign sclRise   = sclSync_q[1] & ~sclSync_q[2];
    assign sclFall   = ~sclSync_q[1] & sclSync_q[2];
    assign startSeen = sclSync_q[1] & sclSync_q[2] & ~sdaSync_q[1] & sdaSync_q[2];
    assign stopSeen  = sclSync_q[1] & sclSync_q[2] & sdaSync_q[1] & ~sdaSync_q[2];

    always @(posedge clk) begin
        if (!rstn) begin
            sclSync_q <= 3'h7;
            sdaSync_q <= 3'h7;
            state_q   <= ST_IDLE;
            bitCnt_q  <= 4'h0;
            shift_q   <= 8'h00;
            first_q   <= 1'b1;
            ptr_q     <= 8'h00;
            sdaOeN_q  <= 1'b1;
            wrEn_q    <= 1'b0;
            wrIdx_q   <= 8'h00;
            wrData_q  <= 8'h00;
        end else begin
            sclSync_q <= {sclSync_q[1:0], sclIn};
            sdaSync_q <= {sdaSync_q[1:0], sdaIn};
            wrEn_q    <= 1'b0;
            if (startSeen) begin
                state_q  <= ST_ADDR;
                bitCnt_q <= 4'h0;
                first_q  <= 1'b1;
                sdaOeN_q <= 1'b1;
            end else if (stopSeen) begin
                state_q  <= ST_IDLE;
                sdaOeN_q <= 1'b1;
            end else if (sclRise && (state_q == ST_ADDR || state_q == ST_DATA)) begin
                shift_q  <= {shift_q[6:0], sdaSync_q[1]};
                bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall) begin
                case (state_q)
                    ST_ADDR: begin
                        if (bitCnt_q == `RGBD_BIT_LAST) begin
                            // only writes to our address are acknowledged
                            if (shift_q == {`RGBD_I2C_ADDR, 1'b0}) begin
                                state_q  <= ST_ACK;
                                sdaOeN_q <= 1'b0;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_DATA: begin
                        if (bitCnt_q == `RGBD_BIT_LAST) begin
                            state_q  <= ST_ACK;
                            sdaOeN_q <= 1'b0;
                            if (first_q) begin
                                ptr_q   <= shift_q;
                                first_q <= 1'b0;
                            end else begin
                                wrEn_q   <= 1'b1;
                                wrIdx_q  <= ptr_q;
                                wrData_q <= shift_q;
                                ptr_q    <= ptr_q + 8'h01;
                            end
                        end
                    end
                    ST_ACK: begin
                        state_q  <= ST_DATA;
                        bitCnt_q <= 4'h0;
                        sdaOeN_q <= 1'b1;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // rgbd_i2c_target

`default_nettype wire

// ===== testbench/rgbd_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rgbd_monitor #(
    parameter [31:0] LOOP_CYC = 32'd200
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // i2c
    input wire logic sclIn,
    input wire logic sdaOeN,
    // led channels
    input wire logic ledRed,
    input wire logic ledGreen,
    input wire logic ledBlue,
    // status
    input wire logic gamutErr_q,
    input wire logic passStrobe_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    reg  [31:0] gap_q;
    reg         seen_q;
    wire        ledAny = ledRed | ledGreen | ledBlue;
    always @(posedge clk) begin
        gap_q  <= (!rstn || passStrobe_q) ? 32'h0 : gap_q + 32'h1;
        seen_q <= rstn && (seen_q || passStrobe_q);
    end
    property p_gap; seen_q && passStrobe_q |-> gap_q == LOOP_CYC - 1; endproperty
    a_gap: assert property (p_gap) else $error("pass length off");
    property p_pulse; passStrobe_q |=> !passStrobe_q; endproperty
    a_pulse: assert property (p_pulse) else $error("strobe too long");
    property p_init; $rose(rstn) |-> !passStrobe_q [*8]; endproperty
    a_init: assert property (p_init) else $error("pass before init");
    property p_rst; $rose(rstn) |-> sdaOeN && !ledAny && !gamutErr_q && !passStrobe_q;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    property p_off; gamutErr_q && $past(gamutErr_q) |-> !ledAny; endproperty
    a_off: assert property (p_off) else $error("led on in error");
    // error flag only moves in the drive step
    property p_errt; $changed(gamutErr_q) |-> gap_q <= 2 || !seen_q; endproperty
    a_errt: assert property (p_errt) else $error("error flag off step");
    property p_ackl; $fell(sdaOeN) |-> !sclIn; endproperty
    a_ackl: assert property (p_ackl) else $error("ack while scl high");
    property p_ackh; $fell(sdaOeN) |-> !sdaOeN [*8]; endproperty
    a_ackh: assert property (p_ackh) else $error("ack too short");
    property p_ackr; $fell(sdaOeN) |-> ##[8:24] sdaOeN; endproperty
    a_ackr: assert property (p_ackr) else $error("ack not released");
    c_pass: cover property (passStrobe_q);
    c_err: cover property ($rose(gamutErr_q));
    c_ack: cover property ($fell(sdaOeN));
endmodule // rgbd_monitor
`default_nettype wire

// ===== testbench/rgbd_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
module rgbd_i2c_master (
    // bus lines
    output logic      scl,
    output logic      sdaDrv,
    input  wire logic sdaLine
);
    // scl parks high between frames, like a real master
    initial begin
        scl    = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic put_byte(input logic [7:0] b, output logic nak);
        for (int i = 7; i >= 0; i--) begin
            sdaDrv = b[i];
            #20 scl = 1'b1;
            #40 scl = 1'b0;
            #20;
        end
        // release so the pull-up shows unless the target acks
        sdaDrv = 1'b1;
        #20 scl = 1'b1;
        #20 nak = sdaLine;
        #20 scl = 1'b0;
        #20;
    endtask
    task automatic frame(input logic [7:0] adr, input logic [47:0] dat, output int naks);
        logic n;
        naks = 0;
        sdaDrv = 1'b0;
        #20 scl = 1'b0;
        #20 put_byte(adr, n);
        naks += (n !== 1'b0);
        for (int k = 5; k >= 0; k--) begin
            put_byte(dat[k*8 +: 8], n);
            naks += (n !== 1'b0);
        end
        sdaDrv = 1'b0;
        #20 scl = 1'b1;
        #20 sdaDrv = 1'b1;
        #20;
    endtask
endmodule // rgbd_i2c_master
`default_nettype wire

// ===== testbench/rgbd_controller_test.sv
`timescale 1ns/1ps
`default_nettype none
module rgbd_controller_test;
    localparam int LOOP = 200;
    logic       clk    = 1'b0;
    logic       rstn   = 1'b0;
    logic [7:0] tempIn = 8'h00;
    wire        scl, sdaDrv, sdaOeN, ledRed, ledGreen, ledBlue, gamutErr_q, passStrobe_q;
    // open drain with pull-up
    wire        sda = sdaDrv & sdaOeN;
    int         error_cnt = 0;
    int         total_checks = 0;
    initial forever #2.5 clk = ~clk;
    rgbd_i2c_master m (.scl(scl), .sdaDrv(sdaDrv), .sdaLine(sda));
    rgbd_controller #(.LOOP_CYC(LOOP)) dut (.clk(clk), .rstn(rstn), .sclIn(scl),
        .sdaIn(sda), .sdaOeN(sdaOeN), .tempIn(tempIn), .ledRed(ledRed),
        .ledGreen(ledGreen), .ledBlue(ledBlue), .gamutErr_q(gamutErr_q),
        .passStrobe_q(passStrobe_q));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    function automatic logic [7:0] dimOf(input int w, input int f);
        longint v;
        v = (longint'(w) * (f > 200 ? 200 : f) * 8557) >>> 26;
        return (v > 255) ? 8'hff : v[7:0];
    endfunction
    task automatic wait_pass(input int n);
        int t;
        t = 0;
        repeat (n) begin
            tick;
            while (passStrobe_q !== 1'b1 && t < 4 * LOOP) begin
                tick;
                t++;
            end
        end
        chk("strobe", 16'h1, {15'h0, passStrobe_q});
    endtask
    // lfsr walks all 255 states, so 255 cycles show level exactly
    task automatic dens(input logic [7:0] r, g, b, input logic e);
        logic [15:0] cr, cg, cb;
        cr = 16'h0;
        cg = 16'h0;
        cb = 16'h0;
        repeat (255) begin
            tick;
            cr += ledRed;
            cg += ledGreen;
            cb += ledBlue;
        end
        chk("red", {8'h0, r}, cr);
        chk("green", {8'h0, g}, cg);
        chk("blue", {8'h0, b}, cb);
        chk("gamut", {15'h0, e}, {15'h0, gamutErr_q});
    endtask
    task automatic mix(input int x, input int y, input int f);
        int   naks;
        logic bad;
        bad = (x + y > 10000);
        m.frame(8'h54, {8'h00, 16'(x), 16'(y), 8'(f)}, naks);
        chk("acks", 16'h0, 16'(naks));
        wait_pass(3);
        dens(bad ? 8'h0 : dimOf(x, f), bad ? 8'h0 : dimOf(y, f),
             bad ? 8'h0 : dimOf(10000 - x - y, f), bad);
    endtask
    task automatic t_reset;
        chk("oe", 16'h1, {15'h0, sdaOeN});
        chk("leds", 16'h0, {13'h0, ledRed, ledGreen, ledBlue});
    endtask
    task automatic t_pass;
        int n;
        wait_pass(1);
        n = 0;
        do begin
            tick;
            n++;
        end while (passStrobe_q !== 1'b1 && n < 4 * LOOP);
        chk("pass len", 16'(LOOP), 16'(n));
    endtask
    task automatic t_weights;
        mix(10000, 0, 200);
        mix(0, 10000, 200);
        mix(0, 0, 200);
    endtask
    task automatic t_half;
        mix(10000, 0, 100);
    endtask
    task automatic t_clip;
        mix(5000, 5000, 255);
    endtask
    task automatic t_gamut;
        mix(8000, 8000, 200);
        mix(10000, 0, 200);
    endtask
    task automatic t_badaddr;
        int naks;
        m.frame(8'h56, 48'h0, naks);
        chk("nak addr", 16'h7, 16'(naks));
        m.frame(8'h55, 48'h0, naks);
        chk("nak read", 16'h7, 16'(naks));
        wait_pass(3);
        dens(8'hff, 8'h0, 8'h0, 1'b0);
    endtask
    // hot board: limit 200 - (200 - 80) = 80 lm; four passes hold a temp then a mix
    task automatic t_temp;
        int naks;
        tempIn = 8'hc8;
        m.frame(8'h54, {8'h00, 16'd10000, 16'd0, 8'd200}, naks);
        chk("acks", 16'h0, 16'(naks));
        wait_pass(4);
        dens(dimOf(10000, 80), 8'h0, 8'h0, 1'b0);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1;
        t_reset;
        rstn = 1'b1;
        t_pass;
        t_weights;
        t_half;
        t_clip;
        t_gamut;
        t_badaddr;
        t_temp;
        close_out;
    end
    initial begin
        #400000;
        error_cnt++;
        close_out;
    end
endmodule // rgbd_controller_test
bind rgbd_controller rgbd_monitor #(.LOOP_CYC(LOOP_CYC)) mon (.clk(clk), .rstn(rstn),
    .sclIn(sclIn), .sdaOeN(sdaOeN), .ledRed(ledRed), .ledGreen(ledGreen),
    .ledBlue(ledBlue), .gamutErr_q(gamutErr_q), .passStrobe_q(passStrobe_q));
`default_nettype wire
